/* File: verilog/sac_pkg.sv */
// Package with constants and types for the converter control block.
package sac_pkg;
  // Result width and configuration word length.
  localparam int unsigned RES_W    = 12;
  localparam int unsigned CFG_W    = 6;
  // Configuration bit positions, counted from 1 in arrival order.
  localparam int unsigned CFG_SD   = 1;
  localparam int unsigned CFG_OS   = 2;
  localparam int unsigned CFG_UNI  = 5;
  // Clock period and conversion times in nanoseconds.
  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned CONV_TYP_NS  = 1300;
  localparam int unsigned CONV_MAX_NS  = 1600;
  // Typical and longest conversion times in clock cycles, rounded down.
  localparam int unsigned CONV_CYC     = CONV_TYP_NS / CLK_NS;
  localparam int unsigned CONV_MAX_CYC = CONV_MAX_NS / CLK_NS;
  localparam int unsigned CNT_W        = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
  localparam logic [RES_W-1:0] RES_MID  = 12'h800;
  localparam logic [CFG_W-1:0] CFG_ZERO = 6'h00;

  // Conversion states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_CONV  = 3'b010,
    ST_SLEEP = 3'b100
  } sac_state_t;

  // Serial port pins seen by the device.
  typedef struct packed {
    logic conversion_trigger;
    logic sck;
    logic sdi;
  } sac_link_in_t;

  // Serial data out with its output enable.
  typedef struct packed {
    logic sdo;
    logic sdo_oe;
  } sac_link_out_t;
endpackage : sac_pkg

/* File: verilog/sac_sync.sv */
// Three-stage input synchroniser with agreement detection.
`timescale 1ns/1ps
module sac_sync (
  input  wire logic ref_clk,  // Block clock.
  input  wire logic rstn,     // Asynchronous reset, active low.
  input  wire logic din,      // Asynchronous input.
  output logic      level,    // Filtered level.
  output logic      rise,     // One-cycle rising pulse.
  output logic      fall      // One-cycle falling pulse.
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic nxt_lvl;

  // A change counts once the second and third stages agree.
  assign nxt_lvl = (s2_ff == s3_ff) ? s2_ff : lvl_ff;
  assign level   = lvl_ff;
  assign rise    = nxt_lvl & ~lvl_ff;
  assign fall    = ~nxt_lvl & lvl_ff;

  // Shift chain and filtered level.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end else begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end
endmodule : sac_sync

/* File: verilog/sac_core.sv */
// Conversion timing and serial readout for the 12-bit converter.
`timescale 1ns/1ps
// Functional notes
// - Trigger rising edge starts a conversion.
// - Internal clock times each conversion.
// - Serial output enabled only while trigger low.
// - Bipolar twos complement, unipolar straight binary.
// - Trigger low at end: MSB out, stay awake.
// - Four-wire port: trigger, clock, data in, out.
// - Config sampled on first six rising clocks.
// - Output changes on falling serial clock.
// - Config bits: sd 1, odd 2, unipolar 5.
// - Trigger high after conversion puts device asleep.
module sac_core
  import sac_pkg::*;
(
  input  wire logic                 ref_clk,     // Block clock, 100 MHz.
  input  wire logic                 rstn,        // Asynchronous reset, active low.
  input  wire sac_pkg::sac_link_in_t link_in,    // Trigger, serial clock, serial in.
  input  wire logic [11:0]          sample_code, // Offset-binary code from the SAR.
  output sac_pkg::sac_link_out_t    link_out,    // Serial out and its enable.
  output logic                      asleep,      // High while powered down.
  output logic                      converting,  // High during a conversion.
  output logic                      diff_select, // Single-ended/differential config bit.
  output logic                      odd_select   // Odd/sign config bit.
);
  import sac_pkg::*;

  logic trig_lvl, trig_rise, trig_fall;
  logic sck_rise, sck_fall, sdi_lvl;
  sac_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [RES_W-1:0] shift_ff;
  logic [3:0]       bitcnt_ff;
  logic [CFG_W-1:0] cfg_ff;
  logic             unipolar_select_ff;
  logic             diff_ff;
  logic             odd_ff;
  logic             sdo_ff;
  logic             oe_ff;
  logic             asleep_ff;
  logic             converting_ff;
  logic             conv_done;

  // Synchronise the pins from the host.
  sac_sync u_trig (.ref_clk(ref_clk), .rstn(rstn), .din(link_in.conversion_trigger),
                   .level(trig_lvl), .rise(trig_rise), .fall(trig_fall));
  sac_sync u_sck  (.ref_clk(ref_clk), .rstn(rstn), .din(link_in.sck),
                   .level(), .rise(sck_rise), .fall(sck_fall));
  sac_sync u_sdi  (.ref_clk(ref_clk), .rstn(rstn), .din(link_in.sdi),
                   .level(sdi_lvl), .rise(), .fall());

  assign conv_done = (state_ff == ST_CONV) && (cnt_ff == CNT_W'(CONV_CYC - 1));

  // Conversion state machine; the busy flag moves with it so the output leaves a flop.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff      <= ST_IDLE;
      converting_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE, ST_SLEEP: begin
          if (trig_rise) begin
            state_ff      <= ST_CONV;
            converting_ff <= 1'b1;
          end else if (state_ff == ST_SLEEP && !trig_lvl) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_CONV: begin
          if (conv_done) begin
            state_ff      <= trig_lvl ? ST_SLEEP : ST_IDLE;
            converting_ff <= 1'b0;
          end
        end
        default: begin
          state_ff      <= ST_IDLE;
          converting_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= CNT_ZERO;
    end else if (state_ff != ST_CONV) begin
      cnt_ff <= CNT_ZERO;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Sleep indicator: asleep only after a conversion with trigger high.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      asleep_ff <= 1'b0;
    end else begin
      asleep_ff <= (conv_done && trig_lvl) || (state_ff == ST_SLEEP && trig_lvl && !trig_rise);
    end
  end

  // Result latch and shift register.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shift_ff  <= RES_ZERO;
      bitcnt_ff <= BIT_ZERO;
    end else if (conv_done) begin
      shift_ff  <= unipolar_select_ff ? sample_code : (sample_code ^ RES_MID);
      bitcnt_ff <= BIT_ZERO;
    end else if (trig_fall) begin
      bitcnt_ff <= BIT_ZERO;
    end else if (!trig_lvl && state_ff != ST_CONV && sck_fall
                 && bitcnt_ff != 4'(RES_W)) begin
      shift_ff  <= {shift_ff[RES_W-2:0], 1'b0};
      bitcnt_ff <= bitcnt_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ff <= CFG_ZERO;
    end else if (trig_fall || conv_done) begin
      cfg_ff <= CFG_ZERO;
    end else if (!trig_lvl && state_ff != ST_CONV && sck_rise && !cfg_ff[CFG_W-1]) begin
      cfg_ff <= {cfg_ff[CFG_W-2:0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      diff_ff            <= 1'b0;
      odd_ff             <= 1'b0;
      unipolar_select_ff <= 1'b0;
    end else if (!trig_lvl && state_ff != ST_CONV && sck_rise && !cfg_ff[CFG_W-1]) begin
      if (cfg_ff == CFG_ZERO) begin
        diff_ff <= sdi_lvl;
      end
      if (cfg_ff[CFG_OS-2] && !cfg_ff[CFG_OS-1]) begin
        odd_ff <= sdi_lvl;
      end
      if (cfg_ff[CFG_UNI-2] && !cfg_ff[CFG_UNI-1]) begin
        unipolar_select_ff <= sdi_lvl;
      end
    end
  end

  // Serial output and enable.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sdo_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else begin
      oe_ff  <= !trig_lvl && state_ff != ST_CONV;
      sdo_ff <= shift_ff[RES_W-1];
    end
  end

  assign link_out.sdo    = sdo_ff;
  assign link_out.sdo_oe = oe_ff;
  assign asleep          = asleep_ff;
  assign converting      = converting_ff;
  assign diff_select     = diff_ff;
  assign odd_select      = odd_ff;

  // Conversion lasts exactly the fixed count, neither a cycle more nor less.
  localparam int CONV_TAIL = CONV_CYC - 8;
  sequence s_start;
    trig_rise && state_ff != ST_CONV;
  endsequence
  sequence s_conv_run;
    (state_ff == ST_CONV) [*8] ##CONV_TAIL (state_ff == ST_CONV) ##1 (state_ff != ST_CONV);
  endsequence
  property p_conv_len;
    @(posedge ref_clk) disable iff (!rstn)
      s_start |=> s_conv_run;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_no_restart;
    @(posedge ref_clk) disable iff (!rstn)
      (state_ff == ST_CONV && !conv_done) |=> state_ff == ST_CONV && cnt_ff != CNT_ZERO;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

  property p_oe_low;
    @(posedge ref_clk) disable iff (!rstn)
      trig_lvl |=> !oe_ff;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("output enabled with trigger high");

  property p_sleep;
    @(posedge ref_clk) disable iff (!rstn)
      (conv_done && trig_lvl) |=> asleep_ff && state_ff == ST_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after conversion");

  property p_awake;
    @(posedge ref_clk) disable iff (!rstn)
      (conv_done && !trig_lvl) |=> !asleep_ff ##1 sdo_ff == $past(shift_ff[RES_W-1]);
  endproperty
  a_awake: assert property (p_awake) else $error("msb not shown or asleep");

  property p_shift;
    @(posedge ref_clk) disable iff (!rstn)
      (sck_fall && oe_ff && !trig_fall && bitcnt_ff != 4'(RES_W))
        |=> bitcnt_ff == $past(bitcnt_ff) + 4'h1;
  endproperty
  a_shift: assert property (p_shift) else $error("no shift on falling clock");

  property p_format;
    @(posedge ref_clk) disable iff (!rstn)
      conv_done |=> shift_ff[RES_W-1] ==
                    ($past(sample_code[RES_W-1]) ^ !$past(unipolar_select_ff));
  endproperty
  a_format: assert property (p_format) else $error("wrong output format");

  property p_cfg_count;
    @(posedge ref_clk) disable iff (!rstn)
      cfg_ff[CFG_W-1] && sck_rise |=> $stable(unipolar_select_ff) && $stable(diff_ff);
  endproperty
  a_cfg_count: assert property (p_cfg_count) else $error("config past six bits");
endmodule : sac_core

/* File: testbench/sac_host.sv */
// Host controller model that drives the converter's serial port.
`timescale 1ns/1ps
module sac_host (
  input  wire logic                   ref_clk,  // Block clock.
  output sac_pkg::sac_link_in_t       link_in,  // Trigger, serial clock, serial in.
  input  wire sac_pkg::sac_link_out_t link_out  // Serial out seen by the host.
);
  import sac_pkg::*;
  realtime last_rise = -1.0e6;
  realtime last_cfg  = -1.0e6;
  // An undriven data line reads back inverted, so a dropped enable shows up as bad data.
  logic sdo_seen;
  assign sdo_seen = link_out.sdo_oe ? link_out.sdo : ~link_out.sdo;
  // Serial clock idles low and the trigger starts low.
  initial link_in = '0;
  task automatic trig(input logic v);
    while (v && ($realtime - last_rise < 2000.0 || $realtime - last_cfg < 240.0))
      @(posedge ref_clk);
    @(posedge ref_clk) #1;
    link_in.conversion_trigger = v;
    if (v) last_rise = $realtime;
  endtask : trig
  task automatic bounce();
    trig(1'b0);
    repeat (10) @(posedge ref_clk);
    #1 link_in.conversion_trigger = 1'b1;
  endtask : bounce
  task automatic frame(input logic [5:0] c, output logic [11:0] w);
    for (int i = 0; i < 12; i++) begin
      link_in.sdi = (i < 6) ? c[i] : ~link_in.sdi;
      #31.25 w[11-i] = sdo_seen;
      link_in.sck = 1'b1;
      #62.5 link_in.sck = 1'b0;
      #31.25;
    end
    link_in.sdi = ~link_in.sdi;
    last_cfg = $realtime;
  endtask : frame
endmodule : sac_host

/* File: testbench/sar_adc_convert_and_readout_tb_top.sv */
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module sar_adc_convert_and_readout_tb_top;
  import sac_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rstn = 1'b0;
  logic [11:0]   sample_code = '0;
  sac_link_in_t  link_in;
  sac_link_out_t link_out;
  logic          asleep, converting, diff_select, odd_select;
  logic          unipolar_select = 1'b0;
  int            n_mismatch = 0, samples_checked = 0, cyc = 0;
  logic [11:0]   corner [4] = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
  sac_core u_sac_core (.ref_clk(ref_clk), .rstn(rstn), .link_in(link_in),
    .sample_code(sample_code), .link_out(link_out), .asleep(asleep),
    .converting(converting), .diff_select(diff_select), .odd_select(odd_select));
  sac_host u_sac_host (.ref_clk(ref_clk), .link_in(link_in), .link_out(link_out));
  // Clock generator, 10 ns period.
  initial forever #5 ref_clk = ~ref_clk;
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Cycle counter that also cuts a hang short.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // Bipolar output flips the top bit of the offset-binary code.
  function automatic logic [11:0] exp_code(logic [11:0] c, logic u);
    return u ? c : (c ^ RES_MID);
  endfunction : exp_code
  task automatic wait_to(input int n);
    while (cyc < n) @(posedge ref_clk);
    #1;
  endtask : wait_to
  // One conversion with short or long trigger pulse, then the readout.
  task automatic run_one(input bit sp, input logic [5:0] c, input logic [11:0] code);
    int t0;
    logic [11:0] w, e;
    @(posedge ref_clk) #1 sample_code = code;
    e = exp_code(code, unipolar_select);
    u_sac_host.trig(1'b1);
    t0 = cyc;
    repeat (sp ? 3 : 39) @(posedge ref_clk);
    if (sp) u_sac_host.trig(1'b0);
    else u_sac_host.bounce();
    wait_to(t0 + 120);
    `CHK("busy", 1'b1, converting)
    `CHK("oe", 1'b0, link_out.sdo_oe)
    wait_to(t0 + int'(CONV_MAX_CYC));
    `CHK("busy", 1'b0, converting)
    `CHK("asleep", logic'(~sp), asleep)
    if (!sp) begin
      u_sac_host.trig(1'b0);
      repeat (10) @(posedge ref_clk);
      #1;
      `CHK("awake", 1'b0, asleep)
    end
    `CHK("oe", 1'b1, link_out.sdo_oe)
    `CHK("msb", e[11], link_out.sdo)
    u_sac_host.frame(c, w);
    `CHK("word", e, w)
    unipolar_select = c[4];
    `CHK("diff", c[0], diff_select)
    `CHK("odd", c[1], odd_select)
  endtask : run_one
  // Main sequence: reset, corner codes, then random traffic.
  initial begin
    logic [5:0] c;
    void'($urandom(32'he236_fba9));
    repeat (5) @(posedge ref_clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 12; i++) begin
      c = (i < 4) ? (6'h10 ^ {6{i[0]}}) : 6'($urandom);
      run_one(i[1], c, (i < 4) ? corner[i] : 12'($urandom));
    end
    // Mid-run reset clears every output at once, then one more conversion.
    @(posedge ref_clk) #1 rstn = 1'b0;
    #1;
    `CHK("rst busy", 1'b0, converting)
    `CHK("rst oe", 1'b0, link_out.sdo_oe)
    `CHK("rst asleep", 1'b0, asleep)
    `CHK("rst diff", 1'b0, diff_select)
    `CHK("rst odd", 1'b0, odd_select)
    unipolar_select = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rstn = 1'b1;
    run_one(1'b1, 6'h13, 12'($urandom));
    test_done();
  end
endmodule : sar_adc_convert_and_readout_tb_top
